// >>> hw/switch_reset_sequencer.sv
// Reset sequencer for a three-port switch with optional isolating bridge
//
// Function
// - Fundamental reset pin low resets all logic, cold or warm.
// - Writing one to switch control reset bit starts warm fundamental reset.
// - In bridge mode, either bridge control reset bit starts fundamental reset.
// - Far-side reset pin with propagate bit set gives full fundamental reset.
// - Normal operation follows within 1.0 s; loader bounded by 200 ms.
// - Loader writes trigger side effects at the moment they are written.
// - Port B reset drives GPIO 0 outside bridge mode, port C reset drives GPIO 1.
// - Fundamental reset returns all GPIO to input, tri-stating reset outputs.
// - Hot reset affecting a downstream port asserts its output 250 ns minimum.
// - Hot reset scopes: whole device, all downstream ports, selected ports.
// - Global hot reset returns all GPIO to input mode.
// - Port C hot reset message on global or local, never bridge mode.
// - Bridge capability register cleared only by fundamental reset.
// - Bridge mode accepts far-side hot reset separately from internal resets.
// - Mode value 0x1 is transparent with EEPROM load in fundamental sequence.
// - Hot reset leaves sticky fields unchanged.
// - Global hot reset sends downstream hot reset message before resetting.
// - Downstream port reset outputs are active low, driven low 250 ns.
`timescale 1ns/100ps
module switch_reset_sequencer
#(
  parameter int LOAD_LIMIT_CYC = rstseq_pkg::LOAD_LIMIT_CYC,
  parameter int HOT_MSG_CYC    = rstseq_pkg::HOT_MSG_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        mclk_en,
  input  wire logic        fundamental_reset_pin_n,
  input  wire logic        far_side_reset_pin_n,
  input  wire logic [3:0]  switch_mode_setting,
  input  wire logic        up_hot_ts1,
  input  wire logic        up_dl_down,
  input  wire logic        far_hot_req,
  input  wire logic        eeprom_done,
  input  wire logic        eeprom_wr,
  input  wire logic [7:0]  eeprom_wr_addr,
  input  wire logic [31:0] eeprom_wr_data,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             fund_rst_n,
  output logic             core_rst_n,
  output logic             ds_b_rst_n,
  output logic             ds_c_rst_n,
  output logic             ext_rst_n,
  output logic             hot_msg_b,
  output logic             hot_msg_c,
  output logic             eeprom_start,
  output logic             normal_op,
  output logic [1:0]       gpio_out,
  output logic [1:0]       gpio_oe
);

  localparam int CW = rstseq_pkg::CNT_W;
  localparam int HW = rstseq_pkg::HCNT_W;

  rstseq_pkg::fund_state_t fstate;
  rstseq_pkg::hot_state_t  hstate;
  logic [1:0]  fpin_sync;
  logic [1:0]  farpin_sync;
  logic        far_prev;
  logic [3:0]  mode_s1;
  logic [3:0]  mode_s2;
  logic [3:0]  mode_q;
  logic [CW-1:0] fcnt;
  logic [HW-1:0] hcnt;
  logic        ee_tmo;
  logic        osel;
  logic [1:0]  alt_en;
  logic        prop_int;
  logic        prop_ext;
  logic        far_seen;
  logic [31:0] sticky_reg;
  logic [31:0] cap_reg;
  logic        sc_core;
  logic        sc_b;
  logic        sc_c;
  logic        sc_ext;
  logic        sc_msg_b;
  logic        sc_msg_c;
  logic        sc_out_b;
  logic        sc_out_c;
  logic [1:0]  pulse_act;
  logic [31:0] rd_val;
  logic        rd_hit;

  // ==========================================================================
  // Pin synchronisers; the strap is caught only after reset release
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fpin_sync   <= 2'h0;
      farpin_sync <= 2'h3;
      far_prev    <= 1'b1;
      mode_s1     <= 4'h0;
      mode_s2     <= 4'h0;
    end
    else if (mclk_en)
    begin
      fpin_sync   <= {fpin_sync[0], fundamental_reset_pin_n};
      farpin_sync <= {farpin_sync[0], far_side_reset_pin_n};
      far_prev    <= farpin_sync[1];
      mode_s1     <= switch_mode_setting;
      mode_s2     <= mode_s1;
    end
  end

  // ==========================================================================
  // Write path shared by the bus and the EEPROM loader
  wire ee_fire   = eeprom_wr && (fstate == rstseq_pkg::F_LOAD);
  wire apb_wr    = psel && penable && pready && pwrite;
  wire w_en      = apb_wr || ee_fire;
  wire [7:0]  w_addr = ee_fire ? eeprom_wr_addr : paddr;
  wire [31:0] w_data = ee_fire ? eeprom_wr_data : pwdata;
  wire w_ctrl    = w_en && (w_addr == rstseq_pkg::ADDR_CTRL);
  wire w_bint    = w_en && (w_addr == rstseq_pkg::ADDR_BR_INT);
  wire w_bext    = w_en && (w_addr == rstseq_pkg::ADDR_BR_EXT);
  wire w_status  = w_en && (w_addr == rstseq_pkg::ADDR_STATUS);
  wire w_sticky  = w_en && (w_addr == rstseq_pkg::ADDR_STICKY);
  wire w_cap     = w_en && (w_addr == rstseq_pkg::ADDR_CAP);

  wire isolating_bridge       = mode_q[rstseq_pkg::MODE_NTB_BIT];
  wire prop_any  = prop_int || prop_ext;
  wire far_fall  = far_prev && !farpin_sync[1];
  wire far_fund  = isolating_bridge && far_fall && prop_any;
  wire ext_fund  = isolating_bridge && far_fall && !prop_any;
  wire ext_hold  = isolating_bridge && !farpin_sync[1] && !prop_any;
  wire soft_fund = (w_ctrl && w_data[rstseq_pkg::CTRL_RST])
                || (isolating_bridge && (w_bint || w_bext) && w_data[rstseq_pkg::BR_RST])
                || far_fund;
  wire fund_req  = !fpin_sync[1] || soft_fund;
  wire fund_clr  = (fstate == rstseq_pkg::F_HOLD);
  wire hold_done = fcnt == CW'(rstseq_pkg::PORT_RST_CYC - 1);
  wire ee_need   = (mode_s2 == rstseq_pkg::MODE_TRANS_EE)
                || (mode_s2 == rstseq_pkg::MODE_NTB_EE);
  wire load_end  = eeprom_done || (fcnt == CW'(LOAD_LIMIT_CYC - 1));

  // ==========================================================================
  // Fundamental reset sequence: hold, optional EEPROM load, run
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fstate <= rstseq_pkg::F_HOLD;
      fcnt   <= '0;
    end
    else if (mclk_en)
    begin
      if (fund_req)
      begin
        fstate <= rstseq_pkg::F_HOLD;
        fcnt   <= '0;
      end
      else
        case (fstate)
          rstseq_pkg::F_HOLD:
            if (hold_done)
            begin
              fcnt   <= '0;
              fstate <= ee_need ? rstseq_pkg::F_LOAD : rstseq_pkg::F_RUN;
            end
            else
              fcnt <= fcnt + CW'(1);
          rstseq_pkg::F_LOAD:
            // Timeout keeps the 1 s bring-up bound even if the loader hangs
            if (load_end)
              fstate <= rstseq_pkg::F_RUN;
            else
              fcnt <= fcnt + CW'(1);
          rstseq_pkg::F_RUN:
            fcnt <= '0;
          default:
            fstate <= rstseq_pkg::F_HOLD;
        endcase
    end
  end

  wire hold_exit = !fund_req && fund_clr && hold_done;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_q       <= 4'h0;
      eeprom_start <= 1'b0;
      ee_tmo       <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (hold_exit)
        mode_q <= mode_s2;
      eeprom_start <= hold_exit && ee_need;
      if (fund_clr)
        ee_tmo <= 1'b0;
      else if (fstate == rstseq_pkg::F_LOAD && !eeprom_done && load_end)
        ee_tmo <= 1'b1;
    end
  end

  // ==========================================================================
  // Hot reset sequence: message to link partner first, then reset
  wire h_go    = (hstate == rstseq_pkg::H_IDLE) && !fund_req && !fund_clr;
  wire g_all   = up_hot_ts1 || up_dl_down;
  wire g_ds    = w_ctrl && w_data[rstseq_pkg::CTRL_SRST];
  wire loc_b   = w_ctrl && w_data[rstseq_pkg::CTRL_LOC_B];
  wire loc_c   = w_ctrl && w_data[rstseq_pkg::CTRL_LOC_C];
  wire x_hot   = isolating_bridge && far_hot_req;
  wire glob    = g_all || g_ds;
  wire h_start = h_go && (glob || loc_b || loc_c || x_hot);
  wire osel_in = (osel != rstseq_pkg::OSEL_EXT);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hstate   <= rstseq_pkg::H_IDLE;
      hcnt     <= '0;
      sc_core  <= 1'b0;
      sc_b     <= 1'b0;
      sc_c     <= 1'b0;
      sc_ext   <= 1'b0;
      sc_msg_b <= 1'b0;
      sc_msg_c <= 1'b0;
      sc_out_b <= 1'b0;
      sc_out_c <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (fund_req || fund_clr)
        hstate <= rstseq_pkg::H_IDLE;
      else
        case (hstate)
          rstseq_pkg::H_IDLE:
            if (h_start)
            begin
              hstate   <= rstseq_pkg::H_MSG;
              hcnt     <= '0;
              sc_core  <= g_all;
              sc_b     <= glob || loc_b;
              sc_c     <= glob || loc_c || x_hot;
              sc_ext   <= g_all || x_hot;
              sc_msg_b <= glob || loc_b;
              sc_msg_c <= (glob || loc_c) && !isolating_bridge;
              sc_out_b <= (glob || loc_b) && !isolating_bridge;
              sc_out_c <= isolating_bridge ? ((glob && osel_in) || loc_c || (x_hot && !osel_in))
                              : (glob || loc_c);
            end
          rstseq_pkg::H_MSG:
            if (hcnt == HW'(HOT_MSG_CYC - 1))
            begin
              hcnt   <= '0;
              hstate <= rstseq_pkg::H_RST;
            end
            else
              hcnt <= hcnt + HW'(1);
          rstseq_pkg::H_RST:
            if (hcnt == HW'(rstseq_pkg::PORT_RST_CYC - 1))
              hstate <= rstseq_pkg::H_IDLE;
            else
              hcnt <= hcnt + HW'(1);
          default:
            hstate <= rstseq_pkg::H_IDLE;
        endcase
    end
  end

  wire h_rst   = (hstate == rstseq_pkg::H_RST);
  wire rst_ent = (hstate == rstseq_pkg::H_MSG) && (hcnt == HW'(HOT_MSG_CYC - 1));
  wire glob_go = h_start && glob;
  wire all_go  = h_start && g_all;

  // ==========================================================================
  // Reset outputs, all registered so release is synchronous
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fund_rst_n <= 1'b0;
      core_rst_n <= 1'b0;
      ds_b_rst_n <= 1'b0;
      ds_c_rst_n <= 1'b0;
      ext_rst_n  <= 1'b0;
      hot_msg_b  <= 1'b0;
      hot_msg_c  <= 1'b0;
      normal_op  <= 1'b0;
    end
    else if (mclk_en)
    begin
      fund_rst_n <= !(fund_req || fund_clr);
      core_rst_n <= !(fund_req || fund_clr || (h_rst && sc_core));
      ds_b_rst_n <= !(fund_req || fund_clr || (h_rst && sc_b));
      ds_c_rst_n <= !(fund_req || fund_clr || (h_rst && sc_c));
      ext_rst_n  <= !(fund_req || fund_clr || (h_rst && sc_ext) || ext_hold);
      hot_msg_b  <= (hstate == rstseq_pkg::H_MSG) && sc_msg_b && !fund_req;
      hot_msg_c  <= (hstate == rstseq_pkg::H_MSG) && sc_msg_c && !fund_req;
      normal_op  <= (fstate == rstseq_pkg::F_RUN) && !fund_req;
    end
  end

  // ==========================================================================
  // Downstream port reset outputs on GPIO 0 and 1
  wire [1:0] pulse_load;
  assign pulse_load[0] = rst_ent && sc_out_b;
  assign pulse_load[1] = (rst_ent && sc_out_c) || (ext_fund && osel == rstseq_pkg::OSEL_EXT);

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_port
    port_reset_pulse #(.W(HW)) u_pulse
    (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .mclk_en (mclk_en),
      .load    (pulse_load[gi]),
      .len     (HW'(rstseq_pkg::PORT_RST_CYC)),
      .active  (pulse_act[gi])
    );
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpio_out <= 2'h3;
      gpio_oe  <= 2'h0;
    end
    else if (mclk_en)
    begin
      gpio_out <= ~pulse_act;
      gpio_oe  <= alt_en;
    end
  end

  // ==========================================================================
  // Control registers; sticky and capability survive every hot reset
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osel   <= 1'b0;
      alt_en <= 2'h0;
    end
    else if (mclk_en)
    begin
      if (fund_clr || all_go)
      begin
        osel   <= 1'b0;
        alt_en <= 2'h0;
      end
      else if (glob_go)
        alt_en <= 2'h0;
      else if (w_ctrl)
      begin
        osel   <= w_data[rstseq_pkg::CTRL_OSEL];
        alt_en <= w_data[rstseq_pkg::CTRL_ALT +: 2];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prop_int <= 1'b0;
      prop_ext <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (fund_clr || all_go)
        prop_int <= 1'b0;
      else if (w_bint)
        prop_int <= w_data[rstseq_pkg::BR_PROP];
      if (fund_clr || all_go || ext_fund || (h_start && x_hot))
        prop_ext <= 1'b0;
      else if (w_bext)
        prop_ext <= w_data[rstseq_pkg::BR_PROP];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sticky_reg <= 32'h0000_0000;
      cap_reg    <= 32'h0000_0000;
      far_seen   <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (fund_clr)
      begin
        sticky_reg <= 32'h0000_0000;
        cap_reg    <= 32'h0000_0000;
      end
      else
      begin
        if (w_sticky)
          sticky_reg <= w_data;
        if (w_cap)
          cap_reg <= w_data;
      end
      // Set wins over a clearing write in the same cycle
      if (fund_clr)
        far_seen <= 1'b0;
      else if (ext_fund)
        far_seen <= 1'b1;
      else if (w_status && w_data[rstseq_pkg::ST_FAR])
        far_seen <= 1'b0;
    end
  end

  // ==========================================================================
  // APB slave: one wait state, pready held low until the fundamental sequence ends
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      rstseq_pkg::ADDR_CTRL:
      begin
        rd_val[rstseq_pkg::CTRL_OSEL]     = osel;
        rd_val[rstseq_pkg::CTRL_ALT +: 2] = alt_en;
      end
      rstseq_pkg::ADDR_BR_INT: rd_val[rstseq_pkg::BR_PROP] = prop_int;
      rstseq_pkg::ADDR_BR_EXT: rd_val[rstseq_pkg::BR_PROP] = prop_ext;
      rstseq_pkg::ADDR_STATUS:
      begin
        rd_val[rstseq_pkg::ST_MODE +: 4] = mode_q;
        rd_val[rstseq_pkg::ST_NORMAL]    = normal_op;
        rd_val[rstseq_pkg::ST_HOT]       = (hstate != rstseq_pkg::H_IDLE);
        rd_val[rstseq_pkg::ST_TMO]       = ee_tmo;
        rd_val[rstseq_pkg::ST_FAR]       = far_seen;
      end
      rstseq_pkg::ADDR_STICKY: rd_val = sticky_reg;
      rstseq_pkg::ADDR_CAP:    rd_val = cap_reg;
      default:                 rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (mclk_en)
    begin
      if (psel && penable && !pready && fstate == rstseq_pkg::F_RUN && !fund_req)
      begin
        pready  <= 1'b1;
        pslverr <= !rd_hit;
        prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [7:0] low_b;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      low_b <= 8'h00;
    else if (mclk_en)
      low_b <= gpio_out[0] ? 8'h00 : ((low_b == 8'hff) ? low_b : low_b + 8'h01);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n || !mclk_en);

  property p_fund_pin;
    !fpin_sync[1] |=> !fund_rst_n && !core_rst_n;
  endproperty
  a_fund_pin: assert property (p_fund_pin) else $error("pin reset not applied");

  property p_soft_fund;
    w_ctrl && w_data[rstseq_pkg::CTRL_RST] |=> fstate == rstseq_pkg::F_HOLD && !fund_rst_n;
  endproperty
  a_soft_fund: assert property (p_soft_fund) else $error("control reset ignored");

  property p_bridge_fund;
    isolating_bridge && (w_bint || w_bext) && w_data[rstseq_pkg::BR_RST] |=> !fund_rst_n;
  endproperty
  a_bridge_fund: assert property (p_bridge_fund) else $error("bridge reset ignored");

  property p_far_prop;
    isolating_bridge && far_fall && prop_any |=> !fund_rst_n ##1 fstate == rstseq_pkg::F_HOLD;
  endproperty
  a_far_prop: assert property (p_far_prop) else $error("far reset not propagated");

  property p_load_exit;
    fstate == rstseq_pkg::F_LOAD && eeprom_done && !fund_req |=> ##1 normal_op;
  endproperty
  a_load_exit: assert property (p_load_exit) else $error("no run after load");

  property p_gpio_fund;
    fstate == rstseq_pkg::F_HOLD |-> ##2 gpio_oe == 2'h0;
  endproperty
  a_gpio_fund: assert property (p_gpio_fund) else $error("gpio driven in reset");

  property p_port_len;
    $rose(gpio_out[0]) |-> low_b >= 8'(rstseq_pkg::PORT_RST_CYC);
  endproperty
  a_port_len: assert property (p_port_len) else $error("port B pulse short");

  property p_msg_c_ntb;
    isolating_bridge && $past(isolating_bridge) |-> !hot_msg_c;
  endproperty
  a_msg_c_ntb: assert property (p_msg_c_ntb) else $error("port C message in bridge mode");

  property p_msg_first;
    $fell(ds_b_rst_n) && fund_rst_n |-> $past(hot_msg_b);
  endproperty
  a_msg_first: assert property (p_msg_first) else $error("reset before message");

  property p_sticky;
    h_rst && fstate == rstseq_pkg::F_RUN && !fund_req && !w_sticky && !w_cap |=> $stable(sticky_reg) && $stable(cap_reg);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky lost in hot reset");

  c_load_done: cover property (fstate == rstseq_pkg::F_LOAD ##1 fstate == rstseq_pkg::F_RUN);
  c_local_c:   cover property (loc_c && h_go ##[1:40] $fell(ds_c_rst_n));
  c_ext_fund:  cover property (ext_fund ##1 !ext_rst_n);

endmodule

// >>> inc/rstseq_pkg.sv
// Constants, register map and state types for the switch reset sequencer
package rstseq_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int PORT_RST_NS    = 250;
  localparam int PORT_RST_CYC   = (PORT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_LIMIT_MS  = 200;
  localparam int LOAD_LIMIT_CYC = LOAD_LIMIT_MS * CLK_MHZ * 1000;
  localparam int HOT_MSG_CYC    = 8;
  localparam int CNT_W          = 25;
  localparam int HCNT_W         = 8;

  // ==========================================================================
  // Switch mode straps
  localparam logic [3:0] MODE_TRANS_EE = 4'h1;
  localparam logic [3:0] MODE_NTB_EE   = 4'h9;
  localparam int         MODE_NTB_BIT  = 3;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BR_INT = 8'h04;
  localparam logic [7:0] ADDR_BR_EXT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_STICKY = 8'h10;
  localparam logic [7:0] ADDR_CAP    = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int CTRL_RST    = 0;
  localparam int CTRL_SRST   = 1;
  localparam int CTRL_LOC_B  = 2;
  localparam int CTRL_LOC_C  = 3;
  localparam int CTRL_OSEL   = 4;
  localparam int CTRL_ALT    = 5;
  localparam int BR_RST      = 0;
  localparam int BR_PROP     = 1;
  localparam int ST_MODE     = 0;
  localparam int ST_NORMAL   = 4;
  localparam int ST_HOT      = 5;
  localparam int ST_TMO      = 6;
  localparam int ST_FAR      = 7;
  localparam logic OSEL_EXT  = 1'b1;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {F_HOLD, F_LOAD, F_RUN} fund_state_t;
  typedef enum logic [1:0] {H_IDLE, H_MSG, H_RST} hot_state_t;

endpackage

// >>> hw/port_reset_pulse.sv
// Retriggerable pulse stretcher for one downstream port reset output
`timescale 1ns/100ps
module port_reset_pulse
#(
  parameter int W = 8
)
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         mclk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] len,
  output logic              active
);

  logic [W-1:0] remain;

  // ==========================================================================
  // Active for exactly len cycles after the load edge; a new load restarts it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remain <= '0;
      active <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (load)
      begin
        remain <= len - W'(1);
        active <= 1'b1;
      end
      else if (remain != '0)
        remain <= remain - W'(1);
      else
        active <= 1'b0;
    end
  end

endmodule

// >>> sim/loader_model.sv
// Behavioural EEPROM loader on the far side of the sequencer
`timescale 1ns/100ps
module loader_model
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        eeprom_start,
  output logic             eeprom_done,
  output logic             eeprom_wr,
  output logic [7:0]       eeprom_wr_addr,
  output logic [31:0]      eeprom_wr_data
);
  logic [3:0] cnt;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 4'h0;
    else if (eeprom_start)
      cnt <= 4'h1;
    else if (cnt != 4'h0)
      cnt <= cnt + 4'h1;
  end
  // Config write lands before completion so its effect precedes normal operation
  assign eeprom_wr      = (cnt == 4'h3);
  assign eeprom_wr_addr = rstseq_pkg::ADDR_STICKY;
  // Data not held outside the strobe
  assign eeprom_wr_data = eeprom_wr ? 32'h3c : 32'hffffffc3;
  assign eeprom_done    = (cnt == 4'h9);
endmodule

// >>> sim/test_switch_reset_sequencer.sv
// Self-checking bench for the switch reset sequencer
`timescale 1ns/100ps
module test_switch_reset_sequencer;
  logic        mclk = 0, arst_n = 0, pin_n = 1, ts1 = 0, far_n = 1, dl = 0, fh = 0, ext_n;
  logic [3:0]  mode = rstseq_pkg::MODE_TRANS_EE;
  logic        psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, fund_rst_n, core_rst_n, ds_b_rst_n, ds_c_rst_n;
  logic        hot_msg_b, hot_msg_c, eeprom_start, normal_op, done, wr;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [1:0]  gpio_out, gpio_oe;
  int          failures = 0, n_compared = 0, k, n, nb, nc, cl, nd, ne, mc;
  always #5 mclk = ~mclk;
  switch_reset_sequencer #(.LOAD_LIMIT_CYC(200)) DUT
  (
    .mclk, .arst_n, .mclk_en(1'b1), .fundamental_reset_pin_n(pin_n), .far_side_reset_pin_n(far_n),
    .switch_mode_setting(mode), .up_hot_ts1(ts1), .up_dl_down(dl),
    .far_hot_req(fh), .eeprom_done(done), .eeprom_wr(wr), .eeprom_wr_addr(wa), .eeprom_wr_data(wd),
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fund_rst_n, .core_rst_n,
    .ds_b_rst_n, .ds_c_rst_n, .ext_rst_n(ext_n), .hot_msg_b, .hot_msg_c, .eeprom_start, .normal_op,
    .gpio_out, .gpio_oe
  );
  loader_model LDR
  (
    .mclk, .arst_n, .eeprom_start, .eeprom_done(done), .eeprom_wr(wr), .eeprom_wr_addr(wa),
    .eeprom_wr_data(wd)
  );
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    // Only the watchdog ends a wait for pready
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_norm;
    int t;
    t = 0;
    while (normal_op !== 1'b1 && t < 2000)
    begin
      @(posedge mclk);
      t++;
    end
    chk("normal_op", normal_op, 1);
  endtask
  task automatic watch;
    nb = 0;
    nc = 0;
    nd = 0;
    ne = 0;
    cl = 0;
    mc = 0;
    repeat (50)
    begin
      @(posedge mclk);
      nb += !gpio_out[0];
      nc += !gpio_out[1];
      nd += !ds_c_rst_n;
      ne += !ext_n;
      cl |= !core_rst_n;
      mc |= hot_msg_c;
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1;
    wait_norm();
    ap(0, 8'h0c, 0);
    chk("status", rd, 32'h11);
    ap(0, 8'h10, 0);
    chk("sticky", rd, 32'h3c);
    ap(1, 8'h10, 32'ha5);
    ap(1, 8'h14, 32'h5a);
    ap(0, 8'h20, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    $display("test boot done");
    for (k = 0; k < 4; k++)
    begin
      ap(1, 8'h00, 32'h60);
      repeat (2) @(posedge mclk);
      chk("gpio_oe", gpio_oe, 2'b11);
      if (k == 0)
      begin
        ts1 <= 1;
        @(posedge mclk);
        ts1 <= 0;
      end
      else
        ap(1, 8'h00, k == 1 ? 32'h62 : (k == 2 ? 32'h64 : 32'h68));
      n = 0;
      while (hot_msg_b !== 1'b1 && hot_msg_c !== 1'b1 && n < 40)
      begin
        @(posedge mclk);
        n++;
      end
      chk("ds_b_before_msg", ds_b_rst_n, 1);
      chk("hot_msg_c", hot_msg_c, k != 2);
      watch();
      chk("b_pulse", 32'(nb), k == 3 ? 0 : rstseq_pkg::PORT_RST_CYC);
      chk("c_pulse", 32'(nc), k == 2 ? 0 : rstseq_pkg::PORT_RST_CYC);
      chk("ds_c", 32'(nd), k == 2 ? 0 : rstseq_pkg::PORT_RST_CYC);
      chk("ext", 32'(ne), k == 0 ? rstseq_pkg::PORT_RST_CYC : 0);
      chk("core_rst", 32'(cl), k == 0);
      chk("oe_after", gpio_oe, k >= 2 ? 2'b11 : 2'b00);
      $display("test hot %0d done", k);
    end
    ap(0, 8'h10, 0);
    chk("sticky_hot", rd, 32'ha5);
    ap(0, 8'h14, 0);
    chk("cap_hot", rd, 32'h5a);
    for (k = 0; k < 2; k++)
    begin
      ap(1, 8'h00, 32'h60);
      if (k == 0)
      begin
        pin_n <= 0;
        repeat (3) @(posedge mclk);
        pin_n <= 1;
      end
      else
        ap(1, 8'h00, 32'h61);
      repeat (4) @(posedge mclk);
      chk("fund", {fund_rst_n, gpio_oe}, 0);
      wait_norm();
      ap(0, 8'h10, 0);
      chk("sticky_fund", rd, 32'h3c);
      ap(0, 8'h14, 0);
      chk("cap_fund", rd, 0);
      $display("test fundamental %0d done", k);
    end
    // Bridge mode is taken from the strap at the end of a fundamental hold
    mode <= rstseq_pkg::MODE_NTB_EE;
    ap(1, 8'h00, 32'h01);
    wait_norm();
    ap(1, 8'h00, 32'h70);
    fh <= 1;
    @(posedge mclk);
    fh <= 0;
    watch();
    chk("ntb_c_pulse", 32'(nc), rstseq_pkg::PORT_RST_CYC);
    chk("ntb_ds_c", 32'(nd), rstseq_pkg::PORT_RST_CYC);
    chk("ntb_ext", 32'(ne), rstseq_pkg::PORT_RST_CYC);
    chk("ntb_b_core_msg", 32'(nb + cl + mc), 0);
    far_n <= 0;
    repeat (4) @(posedge mclk);
    chk("ext_fund", {fund_rst_n, ext_n}, 2'b10);
    far_n <= 1;
    watch();
    chk("ext_c_pulse", 32'(nc), rstseq_pkg::PORT_RST_CYC);
    chk("ext_core", 32'(cl), 0);
    ap(0, 8'h0c, 0);
    chk("ntb_status", rd, 32'h99);
    ap(1, 8'h04, 32'h02);
    far_n <= 0;
    repeat (4) @(posedge mclk);
    chk("far_prop", fund_rst_n, 0);
    far_n <= 1;
    wait_norm();
    ap(1, 8'h08, 32'h01);
    @(posedge mclk);
    chk("bridge_rst", fund_rst_n, 0);
    wait_norm();
    dl <= 1;
    @(posedge mclk);
    dl <= 0;
    watch();
    chk("ntb_glob_msg_c", 32'(mc), 0);
    chk("ntb_glob_core", 32'(cl), 1);
    chk("ntb_glob_b", 32'(nb), 0);
    chk("ntb_glob_c", 32'(nc), rstseq_pkg::PORT_RST_CYC);
    $display("test bridge done");
    wrap_up();
  end
  initial
  begin
    #100us;
    failures++;
    wrap_up();
  end
endmodule
